// >>> phybc_regs.sv
// Purpose: base control fields, short bus reset request and interrupt bits
// Assumes: all inputs synchronous to clk_sys; apb answers with no wait state
// Notes:   events also feed a read-to-clear status word with a mask
//
// Notes on behaviour
// R1 - self-id link bit is control AND link power
// R2 - link control sets at reset, survives bus reset
// R3 - link power alone keeps interface operational
// R4 - contender to self-id, cleared, written only, kept
// R5 - jitter field always reads zero
// R6 - power class from straps, to self-id, kept
// R7 - watchdog enable sets port event on resume/timeouts
// R8 - short reset request starts 1.3 us reset
// R9 - software should use short resets only
// R10 - legacy network turns short reset into long
// R11 - config timeout flag sets, cleared by one
// R12 - flagged timeouts with watchdog wake the link
// R13 - cable power falling edge sets flag, resets one
// R14 - state timeout sets flag and resets bus
// R15 - enabled port status change sets port event
// R16 - config timeout only with legacy nodes
// R17 - loop outsiders see state timeout instead
// R18 - writing zero leaves clear-by-one bits alone
`timescale 1ns/1ps
module phybc_regs
  import phybc_pkg::*;
#(
  parameter int LONG_CYC = LONG_RESET_CYC
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // link side
  input  wire logic        link_power_status_input,
  output logic             link_on_output,
  output logic             link_if_operational,
  // straps and monitored status
  input  wire logic [2:0]  power_class_straps,
  input  wire logic        cable_power_status_input,
  input  wire logic [2:0]  port_status_change,
  input  wire logic [2:0]  port_interrupt_enable,
  input  wire logic [2:0]  resume_start,
  // arbitration controller
  input  wire logic        config_timeout,
  input  wire logic        state_timeout,
  input  wire logic        legacy_node_present,
  input  wire logic        reset_opportunity,
  input  wire logic        bus_reset,
  output logic             bus_reset_drive,
  output logic             bus_reset_long,
  // self-id fields
  output logic             selfid_link_active,
  output logic             selfid_contender,
  output logic [2:0]       selfid_power_class,
  // interrupt
  output logic             irq
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                 link_active_control;
    logic                 contender;
    logic [2:0]           pwr;
    logic                 loaded;
    logic                 resume_watchdog_enable;
    logic                 short_reset_request;
    logic                 issued;
    logic                 config_timeout_irq;
    logic                 cable_power_irq;
    logic                 state_timeout_irq;
    logic                 port_event_irq;
    logic                 cps_q;
    logic                 link_on;
    logic                 sid_link;
    logic                 busy;
    logic                 long_rst;
    logic [RST_CNT_W-1:0] cnt;
    logic [EVT_W-1:0]     evt;
    logic [EVT_W-1:0]     mask;
    logic [31:0]          rdata;
  } phybc_state_s;

  phybc_state_s s;
  phybc_state_s next_s;

  localparam int SRC_M1 = SHORT_RESET_CYC - 1;

  // write-one-to-clear with set winning over the clear
  function automatic logic w1c(input logic cur, input logic wr, input logic one, input logic set);
    w1c = (cur & ~(wr & one)) | set;
  endfunction

  logic wr_acc;
  logic rd_acc;
  logic mapped;
  logic wr_ctrl;
  logic wr_irq;
  logic set_config_timeout_irq;
  logic set_cable_power_irq;
  logic set_state_timeout_irq;
  logic set_pei;
  logic tmo_set;
  logic srst_go;
  logic [31:0] rd_mux;

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  // zero wait states: read data is captured in the setup cycle
  assign pready  = 1'b1;
  assign mapped  = (paddr == CTRL_ADDR) || (paddr == IRQ_ADDR) ||
                   (paddr == EVT_ADDR) || (paddr == MASK_ADDR);
  assign pslverr = psel & penable & ~mapped;
  assign wr_acc  = psel & penable & pwrite & mapped;
  assign rd_acc  = psel & penable & ~pwrite & mapped;
  assign wr_ctrl = wr_acc & (paddr == CTRL_ADDR);
  assign wr_irq  = wr_acc & (paddr == IRQ_ADDR);

  // read multiplexer, unused bits read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      CTRL_ADDR: begin
        rd_mux[LINK_ACTIVE_CONTROL_BIT]            = s.link_active_control;
        rd_mux[CONT_BIT]             = s.contender;
        rd_mux[JIT_LSB +: 3]         = JITTER_VAL; // R5
        rd_mux[PWR_LSB +: 3]         = s.pwr;
      end
      IRQ_ADDR: begin
        rd_mux[RESUME_WATCHDOG_ENABLE_BIT] = s.resume_watchdog_enable;
        rd_mux[SHORT_RESET_REQUEST_BIT] = s.short_reset_request;
        rd_mux[CONFIG_TIMEOUT_IRQ_BIT] = s.config_timeout_irq;
        rd_mux[CABLE_POWER_IRQ_BIT] = s.cable_power_irq;
        rd_mux[STATE_TIMEOUT_IRQ_BIT] = s.state_timeout_irq;
        rd_mux[PEI_BIT]  = s.port_event_irq;
      end
      EVT_ADDR:  rd_mux[EVT_W-1:0] = s.evt;
      MASK_ADDR: rd_mux[EVT_W-1:0] = s.mask;
      default:   rd_mux = 32'h0000_0000;
    endcase
  end

  // ---------------------------------------------------------------
  // event sources
  // ---------------------------------------------------------------
  // loop healing keeps a pure new-style bus loop free, so this only fires with legacy nodes
  assign set_config_timeout_irq = config_timeout & legacy_node_present; // R16 R17 R11
  assign set_cable_power_irq = s.cps_q & ~cable_power_status_input; // R13
  assign set_state_timeout_irq = state_timeout; // R14 R17
  assign tmo_set  = set_config_timeout_irq | set_cable_power_irq | set_state_timeout_irq;
  assign set_pei  = (|(port_status_change & port_interrupt_enable)) | // R15
                    (s.resume_watchdog_enable & (|resume_start)) | // R7
                    (s.resume_watchdog_enable & tmo_set & ~link_power_status_input); // R7
  assign srst_go  = s.short_reset_request & ~s.issued & reset_opportunity & ~s.busy; // R8

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    // power class straps caught once after reset release
    if (!s.loaded) begin
      next_s.pwr    = power_class_straps; // R6
      next_s.loaded = 1'b1;
    end
    // control register; bus reset leaves these fields alone
    if (wr_ctrl) begin
      next_s.link_active_control     = pwdata[LINK_ACTIVE_CONTROL_BIT]; // R2
      next_s.contender = pwdata[CONT_BIT]; // R4
      next_s.pwr       = pwdata[PWR_LSB +: 3]; // R6
    end
    if (wr_irq) begin
      next_s.resume_watchdog_enable = pwdata[RESUME_WATCHDOG_ENABLE_BIT]; // R7
    end
    // short reset request: bus reset clears, a fresh write wins
    if (bus_reset) begin
      next_s.short_reset_request   = 1'b0; // R8
      next_s.issued = 1'b0;
    end
    if (wr_irq && pwdata[SHORT_RESET_REQUEST_BIT]) begin
      next_s.short_reset_request   = 1'b1; // R8
      next_s.issued = 1'b0;
    end
    if (srst_go) begin
      next_s.issued = 1'b1;
    end
    // clear-by-one flags, zeros leave the bit alone
    next_s.config_timeout_irq = w1c(s.config_timeout_irq, wr_irq, pwdata[CONFIG_TIMEOUT_IRQ_BIT], set_config_timeout_irq); // R11 R18
    next_s.cable_power_irq = w1c(s.cable_power_irq, wr_irq, pwdata[CABLE_POWER_IRQ_BIT], set_cable_power_irq); // R13 R18
    next_s.state_timeout_irq = w1c(s.state_timeout_irq, wr_irq, pwdata[STATE_TIMEOUT_IRQ_BIT], set_state_timeout_irq); // R14 R18
    next_s.port_event_irq  = w1c(s.port_event_irq,  wr_irq, pwdata[PEI_BIT],  set_pei); // R15 R18
    next_s.cps_q = cable_power_status_input;
    // wake the link while a timeout flag waits and the link sleeps
    next_s.link_on = s.resume_watchdog_enable & (s.config_timeout_irq | s.cable_power_irq | s.state_timeout_irq) & ~link_power_status_input; // R12
    next_s.sid_link = s.link_active_control & link_power_status_input; // R1
    // bus reset generator; state timeout forces a long reset unless a reset is already running
    if (s.busy) begin
      if (s.cnt == '0) begin
        next_s.busy = 1'b0;
      end else begin
        next_s.cnt = s.cnt - 1'b1;
      end
    end
    if (set_state_timeout_irq && !s.busy) begin
      next_s.busy     = 1'b1; // R14
      next_s.long_rst = 1'b1;
      next_s.cnt      = RST_CNT_W'(LONG_CYC - 1);
    end else if (srst_go) begin
      // legacy phys cannot do short resets, so fall back to long
      next_s.busy     = 1'b1;
      next_s.long_rst = legacy_node_present; // R10
      next_s.cnt      = legacy_node_present ? RST_CNT_W'(LONG_CYC - 1)
                                            : RST_CNT_W'(SRC_M1); // R8
    end
    // system event status: read clears, new event wins
    if (wr_acc && paddr == MASK_ADDR) begin
      next_s.mask = pwdata[EVT_W-1:0];
    end
    if (rd_acc && paddr == EVT_ADDR) begin
      next_s.evt = '0;
    end
    next_s.evt = next_s.evt | {srst_go, set_pei, set_state_timeout_irq, set_cable_power_irq, set_config_timeout_irq};
    // read data ready for the access cycle
    next_s.rdata = (psel && !penable) ? rd_mux : s.rdata;
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s           <= '0;
      s.link_active_control     <= LINK_ACTIVE_CONTROL_RST; // R2
      s.contender <= CONT_RST; // R4
      s.resume_watchdog_enable      <= RESUME_WATCHDOG_ENABLE_RST; // R7
      s.cable_power_irq      <= CABLE_POWER_IRQ_RST; // R13
      s.cps_q     <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign prdata              = s.rdata;
  assign link_on_output      = s.link_on;
  assign link_if_operational = link_power_status_input; // R3
  assign bus_reset_drive     = s.busy;
  assign bus_reset_long      = s.long_rst;
  assign selfid_link_active  = s.sid_link;
  assign selfid_contender    = s.contender; // R4
  assign selfid_power_class  = s.pwr; // R6
  // level interrupt while any unmasked event is pending
  assign irq = |(s.evt & s.mask);

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  selfid_link_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R1
    ##1 selfid_link_active == ($past(s.link_active_control) & $past(link_power_status_input)))
    else $error("self-id link bit not control and link power");

  link_active_control_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R2
    bus_reset && !wr_ctrl |=> $stable(s.link_active_control) && $stable(s.contender) && $stable(s.pwr))
    else $error("control fields changed on bus reset");

  jitter_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R5
    psel && !penable && paddr == CTRL_ADDR |=> prdata[JIT_LSB +: 3] == 3'h0)
    else $error("jitter field not zero");

  // keyed on the load itself, so the edge that releases reset cannot trip it
  strap_load_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R6
    $rose(s.loaded) |-> s.pwr == $past(power_class_straps))
    else $error("power class not loaded from straps");

  resume_pei_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R7
    s.resume_watchdog_enable && (|resume_start) |=> s.port_event_irq)
    else $error("resume did not set port event");

  tmo_pei_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R7
    s.resume_watchdog_enable && set_state_timeout_irq && !link_power_status_input |=> s.port_event_irq)
    else $error("timeout with link asleep did not set port event");

  short_len_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R8
    srst_go && !legacy_node_present && !set_state_timeout_irq
      |=> bus_reset_drive ##SRC_M1 bus_reset_drive ##1 !bus_reset_drive)
    else $error("short bus reset length wrong");

  short_reset_request_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R8
    bus_reset && !(wr_irq && pwdata[SHORT_RESET_REQUEST_BIT]) |=> !s.short_reset_request)
    else $error("request bit not cleared by bus reset");

  legacy_long_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R10
    srst_go && legacy_node_present |=> bus_reset_long && bus_reset_drive)
    else $error("legacy network did not get long reset");

  config_timeout_irq_set_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R11
    config_timeout && legacy_node_present |=> s.config_timeout_irq)
    else $error("config timeout not flagged");

  config_timeout_irq_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R16
    !s.config_timeout_irq && !legacy_node_present |=> !s.config_timeout_irq)
    else $error("config timeout without legacy nodes");

  link_wake_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R12
    s.resume_watchdog_enable && s.state_timeout_irq && !link_power_status_input |=> link_on_output)
    else $error("link not woken by pending timeout");

  wake_drop_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R12
    !s.resume_watchdog_enable |=> !link_on_output)
    else $error("link woken without watchdog enable");

  cable_drop_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R13
    $fell(cable_power_status_input) |=> s.cable_power_irq)
    else $error("cable power drop not flagged");

  state_timeout_irq_reset_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R14
    state_timeout && !s.busy |=> s.state_timeout_irq && bus_reset_drive && bus_reset_long)
    else $error("state timeout missed flag or reset");

  w1c_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R18
    wr_irq && !pwdata[CONFIG_TIMEOUT_IRQ_BIT] && s.config_timeout_irq |=> s.config_timeout_irq)
    else $error("zero write cleared flag");

  port_evt_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R15
    wr_irq && pwdata[PEI_BIT] && (|(port_status_change & port_interrupt_enable)) |=> s.port_event_irq)
    else $error("port event lost against clear");

  pei_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R15
    wr_irq && pwdata[PEI_BIT] && !set_pei |=> !s.port_event_irq)
    else $error("port event not cleared by one");

  // a read clear in the same cycle must not swallow the new event
  pei_log_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R15
    set_pei |=> s.evt != '0)
    else $error("port event missing from event word");
endmodule

// >>> phybc_pkg.sv
// Purpose: constants for the phy base control and interrupt register bank
// Assumes: 32-bit apb, one register per aligned word
// Notes:   register indices are multiplied by four to form byte addresses
package phybc_pkg;
  // ---------------------------------------------------------------
  // register indices and byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_IDX   = 8'h04;
  localparam logic [7:0] IRQ_IDX    = 8'h05;
  localparam logic [7:0] EVT_IDX    = 8'h08;
  localparam logic [7:0] MASK_IDX   = 8'h09;
  localparam logic [7:0] CTRL_ADDR  = 8'(CTRL_IDX * 4);
  localparam logic [7:0] IRQ_ADDR   = 8'(IRQ_IDX * 4);
  localparam logic [7:0] EVT_ADDR   = 8'(EVT_IDX * 4);
  localparam logic [7:0] MASK_ADDR  = 8'(MASK_IDX * 4);
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int LINK_ACTIVE_CONTROL_BIT   = 7;
  localparam int CONT_BIT    = 6;
  localparam int JIT_LSB     = 3;
  localparam int PWR_LSB     = 0;
  localparam int RESUME_WATCHDOG_ENABLE_BIT    = 7;
  localparam int SHORT_RESET_REQUEST_BIT    = 6;
  localparam int CONFIG_TIMEOUT_IRQ_BIT    = 5;
  localparam int CABLE_POWER_IRQ_BIT    = 4;
  localparam int STATE_TIMEOUT_IRQ_BIT    = 3;
  localparam int PEI_BIT     = 2;
  localparam int EVT_W       = 5;
  localparam int EV_SRST_BIT = 4;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic       LINK_ACTIVE_CONTROL_RST  = 1'b1;
  localparam logic       CONT_RST   = 1'b0;
  localparam logic [2:0] JITTER_VAL = 3'h0;
  localparam logic       RESUME_WATCHDOG_ENABLE_RST   = 1'b0;
  localparam logic       CABLE_POWER_IRQ_RST   = 1'b1;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PS          = 8000;
  localparam int SHORT_RESET_PS  = 1300000;
  localparam int LONG_RESET_PS   = 166000000;
  localparam int SHORT_RESET_CYC = (SHORT_RESET_PS + CLK_PS - 1) / CLK_PS;
  localparam int LONG_RESET_CYC  = (LONG_RESET_PS + CLK_PS - 1) / CLK_PS;
  localparam int RST_CNT_W       = 15;
endpackage

// >>> phybc_llc_model.sv
// Purpose: link-layer controller model that drives link power and wakes on request
// Assumes: same clock as the register bank
// Notes:   wakes only after link-on has been seen for three cycles
`timescale 1ns/1ps
module phybc_llc_model (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_b,
  // wake path
  input  wire logic link_on_output,
  input  wire logic llc_awake,
  output logic      link_power_status_input
);
  logic [1:0] on_cnt;
  logic       woken;
  // power-up delay, so a brief link-on does not wake the controller
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      on_cnt                  <= 2'h0;
      woken                   <= 1'b0;
      link_power_status_input <= 1'b0;
    end else begin
      on_cnt                  <= !link_on_output ? 2'h0 : (on_cnt == 2'h3) ? on_cnt : on_cnt + 2'h1;
      woken                   <= llc_awake ? 1'b0 : (woken | (on_cnt == 2'h3));
      link_power_status_input <= llc_awake | woken;
    end
  end
endmodule

// >>> testbench.sv
// Purpose: self-checking bench for the base control and interrupt bank
// Assumes: zero-wait apb, long reset shortened to LC cycles
// Notes:   reads after an edge see the values launched by the previous edge
`timescale 1ns/1ps
module testbench;
  import phybc_pkg::*;
  localparam int LC = 200;
  logic clk_sys = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd_data;
  logic rd_err, link_power_status_input, link_on_output, link_if_operational, llc_awake = 1;
  logic [2:0] power_class_straps = 0, port_status_change = 0, port_interrupt_enable = 0, resume_start = 0;
  logic cable_power_status_input = 1, config_timeout = 0, state_timeout = 0, legacy_node_present = 0;
  logic reset_opportunity = 0, bus_reset = 0, bus_reset_drive, bus_reset_long;
  logic selfid_link_active, selfid_contender;
  logic [2:0] selfid_power_class;
  logic [31:0] d;
  int num_errors = 0, comparisons = 0, n;
  // ---------------------------------------------------------------
  // clock, design and partner
  // ---------------------------------------------------------------
  always #4 clk_sys = ~clk_sys;
  phybc_regs #(.LONG_CYC(LC)) dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_power_status_input(link_power_status_input), .link_on_output(link_on_output),
    .link_if_operational(link_if_operational), .power_class_straps(power_class_straps),
    .cable_power_status_input(cable_power_status_input), .port_status_change(port_status_change),
    .port_interrupt_enable(port_interrupt_enable), .resume_start(resume_start),
    .config_timeout(config_timeout), .state_timeout(state_timeout),
    .legacy_node_present(legacy_node_present), .reset_opportunity(reset_opportunity),
    .bus_reset(bus_reset), .bus_reset_drive(bus_reset_drive), .bus_reset_long(bus_reset_long),
    .selfid_link_active(selfid_link_active), .selfid_contender(selfid_contender),
    .selfid_power_class(selfid_power_class), .irq(irq));
  phybc_llc_model llc (.clk_sys(clk_sys), .rst_b(rst_b), .link_on_output(link_on_output),
    .llc_awake(llc_awake), .link_power_status_input(link_power_status_input));
  // ---------------------------------------------------------------
  // tasks and expectations
  // ---------------------------------------------------------------
  function automatic logic [31:0] ctrl_exp(input logic [7:0] v);
    return {24'h0, v[7:6], JITTER_VAL, v[2:0]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= v; penable <= 1'b0;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd_data, exp);
  endtask
  task automatic test_done;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    test_done();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'h5fd4));
    power_class_straps <= 3'($urandom);
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    // reset values and self-id copies
    rdchk(CTRL_ADDR, ctrl_exp({2'b10, 3'h0, power_class_straps}));
    rdchk(IRQ_ADDR, 32'h10);
    chk(selfid_power_class, power_class_straps);
    chk(selfid_contender, 1'b0);
    chk(selfid_link_active, 1'b1);
    $display("test reset_values done");
    // four random control writes and a last one of 0x4F, then a bus reset must leave them alone
    for (int i = 0; i < 5; i++) begin
      d = (i == 4) ? 32'h4F : $urandom;
      apb(1'b1, CTRL_ADDR, d);
      rdchk(CTRL_ADDR, ctrl_exp(d[7:0]));
      chk(selfid_link_active, d[7] & link_power_status_input);
      chk(selfid_contender, d[6]);
      chk(selfid_power_class, d[2:0]);
      chk(link_if_operational, 1'b1);
    end
    bus_reset <= 1'b1;
    @(posedge clk_sys);
    bus_reset <= 1'b0;
    rdchk(CTRL_ADDR, ctrl_exp(8'h4F));
    $display("test control_fields done");
    // clear-by-one flags and their set conditions
    apb(1'b1, IRQ_ADDR, 32'h0);
    rdchk(IRQ_ADDR, 32'h10);
    apb(1'b1, IRQ_ADDR, 32'h10);
    rdchk(IRQ_ADDR, 32'h0);
    cable_power_status_input <= 1'b0;
    // flag sets at the next edge, read data is caught in the setup cycle after it
    @(posedge clk_sys);
    rdchk(IRQ_ADDR, 32'h10);
    apb(1'b1, IRQ_ADDR, 32'h10);
    config_timeout <= 1'b1;
    @(posedge clk_sys);
    config_timeout <= 1'b0;
    rdchk(IRQ_ADDR, 32'h0);
    legacy_node_present <= 1'b1;
    config_timeout <= 1'b1;
    @(posedge clk_sys);
    config_timeout <= 1'b0;
    rdchk(IRQ_ADDR, 32'h20);
    apb(1'b1, IRQ_ADDR, 32'h20);
    port_status_change <= 3'h2;
    @(posedge clk_sys);
    port_status_change <= 3'h0;
    port_interrupt_enable <= 3'h2;
    resume_start <= 3'h4;
    rdchk(IRQ_ADDR, 32'h0);
    port_status_change <= 3'h2;
    resume_start <= 3'h0;
    @(posedge clk_sys);
    port_status_change <= 3'h0;
    rdchk(IRQ_ADDR, 32'h04);
    apb(1'b1, IRQ_ADDR, 32'h84);
    resume_start <= 3'h1;
    @(posedge clk_sys);
    resume_start <= 3'h0;
    rdchk(IRQ_ADDR, 32'h84);
    $display("test flags done");
    // software-requested resets, short without legacy nodes and long with them
    for (int lg = 0; lg < 2; lg++) begin
      legacy_node_present <= lg[0];
      apb(1'b1, IRQ_ADDR, 32'h44);
      rdchk(IRQ_ADDR, 32'h40);
      reset_opportunity <= 1'b1;
      @(posedge clk_sys);
      reset_opportunity <= 1'b0;
      n = 0;
      while (bus_reset_drive !== 1'b1 && n < 8) begin
        @(posedge clk_sys);
        n++;
      end
      chk(bus_reset_long, lg[0]);
      n = 0;
      while (bus_reset_drive === 1'b1 && n < 30000) begin
        @(posedge clk_sys);
        n++;
      end
      chk(n, lg ? LC : SHORT_RESET_CYC);
      bus_reset <= 1'b1;
      @(posedge clk_sys);
      bus_reset <= 1'b0;
      rdchk(IRQ_ADDR, 32'h0);
    end
    $display("test short_reset done");
    // state time-out with the link asleep wakes it
    apb(1'b1, IRQ_ADDR, 32'h80);
    llc_awake <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk(link_on_output, 1'b0);
    chk(link_if_operational, 1'b0);
    state_timeout <= 1'b1;
    @(posedge clk_sys);
    state_timeout <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk(link_on_output, 1'b1);
    chk(bus_reset_drive, 1'b1);
    chk(bus_reset_long, 1'b1);
    rdchk(IRQ_ADDR, 32'h8C);
    n = 0;
    while (link_on_output === 1'b1 && n < 12) begin
      @(posedge clk_sys);
      n++;
    end
    chk(link_on_output, 1'b0);
    llc_awake <= 1'b1;
    repeat (LC) @(posedge clk_sys);
    $display("test link_wake done");
    // read-to-clear event word, mask and unmapped address
    apb(1'b1, MASK_ADDR, 32'h0);
    apb(1'b0, EVT_ADDR, 32'h0);
    cable_power_status_input <= 1'b1;
    @(posedge clk_sys);
    cable_power_status_input <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk(irq, 1'b0);
    apb(1'b1, MASK_ADDR, 32'h02);
    chk(irq, 1'b1);
    rdchk(EVT_ADDR, 32'h02);
    chk(irq, 1'b0);
    rdchk(8'h3C, 32'h0);
    chk(rd_err, 1'b1);
    $display("test events done");
    test_done();
  end
endmodule
